// *** core/ccr_charger_regs.sv ***
`timescale 1ns/1ns
`include "ccr_defs.svh"

// How it works
// - code 0: charger, linear off, switch on
// - code 1: linear regulator only, no charging
// - code 2 with input charges; 3 reserved
// - operation field defaults 01, fuse loaded
// - writing 0x01 to clear restarts watchdog
// - force-off bit turns battery switch off
// - fast-charge limit code times two hours
// - end-of-charge time code times ten minutes, code 0 is 16 s
// - precharge limit 30 or 45 minutes
// - recharge threshold codes, 3 disables restart
// - termination current in CV starts top-off
// - termination threshold codes, 5-7 reserved
// - core reset restores all defaults
// - watchdog expiry stops charger, sets flag

module ccr_charger_regs
	import ccr_pkg::*;
#(
	parameter int TICK_CYCLES = `CCR_TICK_CYCLES,
	parameter int WDOG_SECONDS = `CCR_WDOG_PERIOD_S
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] otp_charger_operation,
	input wire ccr_analog_t analog_in,
	output ccr_power_t power_ctl,
	output ccr_charge_cfg_t charge_cfg,
	output logic charging_ok_flag,
	output logic watchdog_expired_flag
);

	if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << 26))
	begin
		$error("ccr_charger_regs: TICK_CYCLES out of range");
	end
	if (WDOG_SECONDS < 1 || WDOG_SECONDS > 65535)
	begin
		$error("ccr_charger_regs: WDOG_SECONDS out of range");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] fc_seconds(input logic [2:0] code);
		fc_seconds = 16'(code * `CCR_FC_STEP_HR * `CCR_SEC_PER_HR);
	endfunction

	function automatic logic [15:0] eoc_seconds(input logic [2:0] code);
		if (code == 3'h0)
		begin
			eoc_seconds = 16'(`CCR_EOC_DEBOUNCE_S);
		end
		else
		begin
			eoc_seconds = 16'(code * `CCR_EOC_STEP_MIN * `CCR_SEC_PER_MIN);
		end
	endfunction

	function automatic logic [15:0] pre_seconds(input logic sel);
		pre_seconds = sel ? 16'(`CCR_PRE_LONG_MIN * `CCR_SEC_PER_MIN)
			: 16'(`CCR_PRE_SHORT_MIN * `CCR_SEC_PER_MIN);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	ccr_analog_t ana_meta;
	ccr_analog_t ana;
	logic [1:0] otp_meta;
	logic [1:0] otp_sync;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ana_meta <= '0;
			ana <= '0;
			otp_meta <= 2'h0;
			otp_sync <= 2'h0;
		end
		else
		begin
			ana_meta <= analog_in;
			ana <= ana_meta;
			otp_meta <= otp_charger_operation;
			otp_sync <= otp_meta;
		end
	end

	// ----------------------------------------
	// one-second tick
	// ----------------------------------------
	logic [25:0] tick_count;
	logic [25:0] next_tick_count;
	logic sec_tick;
	logic next_sec_tick;

	always_comb
	begin
		next_tick_count = tick_count + 26'h1;
		next_sec_tick = 1'b0;
		if (tick_count == 26'(TICK_CYCLES - 1))
		begin
			next_tick_count = 26'h0;
			next_sec_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tick_count <= 26'h0;
			sec_tick <= 1'b0;
		end
		else
		begin
			tick_count <= next_tick_count;
			sec_tick <= next_sec_tick;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] oper;
	logic [7:0] tmr;
	logic [7:0] eoc;
	logic wd_flag;
	logic [1:0] otp_wait;
	logic [7:0] next_oper;
	logic [7:0] next_tmr;
	logic [7:0] next_eoc;
	logic next_wd_flag;
	logic [1:0] next_otp_wait;
	logic [7:0] next_rdata;
	logic otp_load;
	logic wr_oper;
	logic wd_clear;
	logic wd_start;
	logic wd_run;
	logic wd_fire;
	ccr_state_t state;

	// fuse pins settle before reset release; sample once the sync chain is full
	assign otp_load = otp_wait == 2'h2;
	assign wr_oper = reg_wr && reg_addr == `CCR_OPER_OFFSET;
	assign wd_clear = reg_wr && reg_addr == `CCR_WDCLR_OFFSET
		&& reg_wdata == `CCR_WDCLR_KEY;
	assign wd_start = wd_clear
		|| (wr_oper && reg_wdata[`CCR_OPER_WDEN_B] && !oper[`CCR_OPER_WDEN_B]);
	assign wd_run = oper[`CCR_OPER_WDEN_B] && !wd_flag;

	always_comb
	begin
		next_oper = oper;
		next_tmr = tmr;
		next_eoc = eoc;
		next_wd_flag = wd_flag;
		next_otp_wait = otp_wait;
		next_rdata = reg_rdata;
		if (otp_wait != 2'h3)
		begin
			next_otp_wait = otp_wait + 2'h1;
		end
		if (otp_load)
		begin
			next_oper[`CCR_OPER_SEL_F] = otp_sync;
		end
		if (wr_oper)
		begin
			next_oper = reg_wdata;
		end
		if (reg_wr && reg_addr == `CCR_TMR_OFFSET)
		begin
			next_tmr = reg_wdata & `CCR_TMR_WMASK;
		end
		if (reg_wr && reg_addr == `CCR_EOC_OFFSET)
		begin
			next_eoc = reg_wdata;
		end
		if (wd_clear || !oper[`CCR_OPER_WDEN_B])
		begin
			next_wd_flag = 1'b0;
		end
		// a clear restarts the count and masks an expiry due in the same cycle
		if (wd_fire)
		begin
			next_wd_flag = 1'b1;
		end
		if (reg_rd)
		begin
			if (reg_addr == `CCR_OPER_OFFSET)
			begin
				next_rdata = oper;
			end
			else if (reg_addr == `CCR_TMR_OFFSET)
			begin
				next_rdata = tmr;
			end
			else if (reg_addr == `CCR_EOC_OFFSET)
			begin
				next_rdata = eoc;
			end
			else if (reg_addr == `CCR_STAT_OFFSET)
			begin
				next_rdata = {2'h0, wd_flag, 2'h0, state};
			end
			else
			begin
				next_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			oper <= `CCR_OPER_RESET;
			tmr <= `CCR_TMR_RESET;
			eoc <= `CCR_EOC_RESET;
			wd_flag <= 1'b0;
			otp_wait <= 2'h0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			oper <= next_oper;
			tmr <= next_tmr;
			eoc <= next_eoc;
			wd_flag <= next_wd_flag;
			otp_wait <= next_otp_wait;
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// timers
	// ----------------------------------------
	logic pre_start;
	logic fc_start;
	logic eoc_start;
	logic pre_expired;
	logic fc_expired;
	logic eoc_expired;

	ccr_countdown #(.WIDTH(16)) u_wdog (.ref_clk(ref_clk), .rst_b(rst_b), .tick(sec_tick),
		.start(wd_start), .run(wd_run), .load_value(16'(WDOG_SECONDS)), .expired(wd_fire));
	ccr_countdown #(.WIDTH(16)) u_pre (.ref_clk(ref_clk), .rst_b(rst_b), .tick(sec_tick),
		.start(pre_start), .run(state == CCR_ST_PRECHG),
		.load_value(pre_seconds(tmr[`CCR_TMR_PRE_B])), .expired(pre_expired));
	ccr_countdown #(.WIDTH(16)) u_fast (.ref_clk(ref_clk), .rst_b(rst_b), .tick(sec_tick),
		.start(fc_start), .run(state == CCR_ST_FAST || state == CCR_ST_TOPOFF),
		.load_value(fc_seconds(tmr[`CCR_TMR_FC_F])), .expired(fc_expired));
	ccr_countdown #(.WIDTH(16)) u_eoc (.ref_clk(ref_clk), .rst_b(rst_b), .tick(sec_tick),
		.start(eoc_start), .run(state == CCR_ST_TOPOFF),
		.load_value(eoc_seconds(tmr[`CCR_TMR_EOC_F])), .expired(eoc_expired));

	// ----------------------------------------
	// charge sequencer
	// ----------------------------------------
	ccr_state_t next_state;
	ccr_power_t next_power;
	ccr_charge_cfg_t next_cfg;
	logic mode_ok;
	logic fc_hit;
	logic next_ok;

	assign mode_ok = oper[`CCR_OPER_SEL_F] == CCR_OP_CHARGE && ana.input_valid
		&& ana.battery_present;
	// code 0 switches the fast-charge limit off
	assign fc_hit = fc_expired && tmr[`CCR_TMR_FC_F] != 3'h0;

	always_comb
	begin
		next_state = state;
		if (wd_fire || wd_flag)
		begin
			next_state = CCR_ST_WDOG;
		end
		else if (!mode_ok)
		begin
			next_state = CCR_ST_IDLE;
		end
		else
		begin
			case (state)
				CCR_ST_IDLE, CCR_ST_WDOG:
					next_state = ana.battery_low ? CCR_ST_PRECHG : CCR_ST_FAST;
				CCR_ST_PRECHG:
					if (pre_expired)
						next_state = CCR_ST_FAULT;
					else if (!ana.battery_low)
						next_state = CCR_ST_FAST;
				CCR_ST_FAST:
					if (fc_hit)
						next_state = CCR_ST_FAULT;
					else if (ana.cv_mode && ana.at_termination)
						next_state = CCR_ST_TOPOFF;
				CCR_ST_TOPOFF:
					if (fc_hit)
						next_state = CCR_ST_FAULT;
					else if (eoc_expired)
						next_state = CCR_ST_DONE;
				CCR_ST_DONE:
					if (ana.below_restart && eoc[`CCR_EOC_RST_F] != `CCR_RESTART_OFF)
						next_state = CCR_ST_FAST;
				CCR_ST_FAULT:
					next_state = CCR_ST_FAULT;
				default:
					next_state = CCR_ST_IDLE;
			endcase
		end
		pre_start = next_state == CCR_ST_PRECHG && state != CCR_ST_PRECHG;
		fc_start = next_state == CCR_ST_FAST && state != CCR_ST_FAST;
		eoc_start = next_state == CCR_ST_TOPOFF && state != CCR_ST_TOPOFF;
		next_power.charger_enable = next_state == CCR_ST_PRECHG
			|| next_state == CCR_ST_FAST || next_state == CCR_ST_TOPOFF;
		// reserved code 3 keeps both paths off
		next_power.linear_enable = oper[`CCR_OPER_SEL_F] == CCR_OP_LINEAR
			|| oper[`CCR_OPER_SEL_F] == CCR_OP_CHARGE;
		next_power.battery_switch = !oper[`CCR_OPER_FORCE_B]
			&& (oper[`CCR_OPER_SEL_F] == CCR_OP_OFF || ana.battery_present);
		next_ok = next_power.charger_enable;
		next_cfg.termination_current_threshold = eoc[`CCR_EOC_TERM_F];
		next_cfg.recharge_threshold = eoc[`CCR_EOC_RST_F];
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= CCR_ST_IDLE;
			power_ctl <= '0;
			charging_ok_flag <= 1'b0;
			charge_cfg <= {`CCR_TERM_RESET, `CCR_RESTART_RESET};
		end
		else
		begin
			state <= next_state;
			power_ctl <= next_power;
			charging_ok_flag <= next_ok;
			charge_cfg <= next_cfg;
		end
	end

	assign watchdog_expired_flag = wd_flag;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	op_off_mode_a: assert property (
		(oper[1:0] == 2'h0 && !oper[4]) |=>
		(!power_ctl.charger_enable && !power_ctl.linear_enable && power_ctl.battery_switch))
		else $error("code 0 must idle both paths with switch on");
	op_linear_mode_a: assert property (
		oper[1:0] == 2'h1 |=> (power_ctl.linear_enable && !power_ctl.charger_enable))
		else $error("code 1 must run linear only");
	charge_needs_input_a: assert property (
		power_ctl.charger_enable |-> ($past(oper[1:0]) == 2'h2 && $past(ana.input_valid)))
		else $error("charging without code 2 and valid input");
	otp_default_load_a: assert property (
		otp_load && !reg_wr |=> oper[1:0] == $past(otp_sync))
		else $error("fuse default not loaded");
	wdog_clear_a: assert property (
		(wd_clear && !wd_fire) |=> !wd_flag ##1 !wd_fire)
		else $error("watchdog clear did not restart period");
	switch_force_off_a: assert property (
		oper[4] |=> !power_ctl.battery_switch)
		else $error("battery switch not forced off");
	fast_limit_fault_a: assert property (
		(state == CCR_ST_FAST && fc_hit && mode_ok && !wd_fire && !wd_flag)
		|=> state == CCR_ST_FAULT)
		else $error("fast-charge limit ignored");
	topoff_done_a: assert property (
		(state == CCR_ST_TOPOFF && eoc_expired && !fc_hit && mode_ok && !wd_fire && !wd_flag)
		|=> state == CCR_ST_DONE)
		else $error("end-of-charge timer ignored");
	precharge_fault_a: assert property (
		(state == CCR_ST_PRECHG && pre_expired && mode_ok && !wd_fire && !wd_flag)
		|=> state == CCR_ST_FAULT)
		else $error("precharge limit ignored");
	restart_disabled_a: assert property (
		(state == CCR_ST_DONE && eoc[1:0] == 2'h3 && mode_ok && !wd_fire && !wd_flag)
		|=> state == CCR_ST_DONE)
		else $error("restart while disabled");
	term_to_topoff_a: assert property (
		(state == CCR_ST_FAST && ana.cv_mode && ana.at_termination && !fc_hit && mode_ok
		&& !wd_fire && !wd_flag) |=> (state == CCR_ST_TOPOFF && power_ctl.charger_enable))
		else $error("termination did not enter top-off");
	wdog_expiry_a: assert property (
		wd_fire |=> (wd_flag && !power_ctl.charger_enable && !charging_ok_flag))
		else $error("watchdog expiry did not stop charger");
	ro_bit_zero_a: assert property (
		(reg_rd && reg_addr == 8'h0a) |=> reg_rdata[6] == 1'b0)
		else $error("read-only unused bit reads 1");

endmodule

// *** core/ccr_defs.svh ***
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCR_STAT_OFFSET 8'h07
`define CCR_OPER_OFFSET 8'h09
`define CCR_TMR_OFFSET 8'h0a
`define CCR_WDCLR_OFFSET 8'h0c
`define CCR_EOC_OFFSET 8'h0d

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define CCR_OPER_RESET 8'h01
`define CCR_TMR_RESET 8'h0a
`define CCR_EOC_RESET 8'h41
`define CCR_TMR_WMASK 8'hbf
`define CCR_WDCLR_KEY 8'h01
`define CCR_TERM_RESET 3'h4
`define CCR_RESTART_RESET 2'h1
`define CCR_RESTART_OFF 2'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCR_OPER_SEL_F 1:0
`define CCR_OPER_WDEN_B 3
`define CCR_OPER_FORCE_B 4
`define CCR_TMR_FC_F 2:0
`define CCR_TMR_EOC_F 5:3
`define CCR_TMR_PRE_B 7
`define CCR_EOC_RST_F 1:0
`define CCR_EOC_TERM_F 6:4

// ----------------------------------------
// timing
// ----------------------------------------
`define CCR_CLK_PERIOD_NS 40
`define CCR_TICK_PERIOD_MS 1000
`define CCR_TICK_CYCLES ((`CCR_TICK_PERIOD_MS * 1000000) / `CCR_CLK_PERIOD_NS)
`define CCR_WDOG_PERIOD_S 32
`define CCR_SEC_PER_MIN 60
`define CCR_SEC_PER_HR 3600
`define CCR_FC_STEP_HR 2
`define CCR_EOC_STEP_MIN 10
`define CCR_EOC_DEBOUNCE_S 16
`define CCR_PRE_SHORT_MIN 30
`define CCR_PRE_LONG_MIN 45

`endif

// *** core/ccr_pkg.sv ***
package ccr_pkg;

	// ----------------------------------------
	// modes and states
	// ----------------------------------------
	typedef enum logic [1:0] {
		CCR_OP_OFF = 2'b00,
		CCR_OP_LINEAR = 2'b01,
		CCR_OP_CHARGE = 2'b10,
		CCR_OP_RSVD = 2'b11
	} ccr_op_t;

	typedef enum logic [2:0] {
		CCR_ST_IDLE = 3'b000,
		CCR_ST_PRECHG = 3'b001,
		CCR_ST_FAST = 3'b010,
		CCR_ST_TOPOFF = 3'b011,
		CCR_ST_DONE = 3'b100,
		CCR_ST_FAULT = 3'b101,
		CCR_ST_WDOG = 3'b110
	} ccr_state_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic input_valid;
		logic battery_present;
		logic battery_low;
		logic cv_mode;
		logic at_termination;
		logic below_restart;
	} ccr_analog_t;

	typedef struct packed {
		logic charger_enable;
		logic linear_enable;
		logic battery_switch;
	} ccr_power_t;

	typedef struct packed {
		logic [2:0] termination_current_threshold;
		logic [1:0] recharge_threshold;
	} ccr_charge_cfg_t;

endpackage

// *** core/ccr_countdown.sv ***
`timescale 1ns/1ns

module ccr_countdown
#(
	parameter int WIDTH = 16
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic start,
	input wire logic run,
	input wire logic [WIDTH-1:0] load_value,
	output logic expired
);

	if (WIDTH < 1 || WIDTH > 32)
	begin
		$error("ccr_countdown: WIDTH out of range");
	end

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	// counts whole ticks; holds while not running so a pause keeps the remaining time
	always_comb
	begin
		next_count = count;
		if (start)
		begin
			next_count = load_value;
		end
		else if (run && tick && count != '0)
		begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count <= '0;
		end
		else
		begin
			count <= next_count;
		end
	end

	assign expired = run && !start && count == '0;

endmodule

// *** sim/ccr_host_model.sv ***
`timescale 1ns/1ns

// ----------------------------------------
// host side of the register port
// ----------------------------------------
// strobes rise 1 ns after an edge and stay up for one edge only
module ccr_host_model
(
	input wire logic ref_clk,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// callers also pass reserved bits, such as 8'hff to the timer register at 0x0a
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~data;
	endtask

	// data is registered, so it is taken one edge after the strobe drops
	task automatic read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = addr;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		@(posedge ref_clk);
		#1;
		data = reg_rdata;
	endtask

	// restart the watchdog before its period runs out
	task automatic wdog_clear();
		write(8'h0c, 8'h01);
	endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns

module tb_top
	import ccr_pkg::*;
;
	logic ref_clk;
	logic rst_b;
	logic reg_rd;
	logic reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [1:0] otp;
	ccr_analog_t ana;
	ccr_power_t power_ctl;
	ccr_charge_cfg_t charge_cfg;
	logic charging_ok_flag;
	logic watchdog_expired_flag;
	int fail_count = 0;
	int check_count = 0;

	// short tick keeps the multi-minute timers inside the run budget
	ccr_charger_regs #(.TICK_CYCLES(4), .WDOG_SECONDS(3)) dut_u
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.otp_charger_operation(otp),
		.analog_in(ana),
		.power_ctl(power_ctl),
		.charge_cfg(charge_cfg),
		.charging_ok_flag(charging_ok_flag),
		.watchdog_expired_flag(watchdog_expired_flag)
	);

	ccr_host_model host_u
	(
		.ref_clk(ref_clk),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host_u.read(addr, d);
		check(d, exp);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		rd_check(8'h09, 8'h02);
		rd_check(8'h0a, 8'h0a);
		rd_check(8'h0d, 8'h41);
		check({3'h0, charge_cfg}, 8'h11);
		rd_check(8'h07, 8'h00);
		rd_check(8'h20, 8'h00);
	endtask

	task automatic t_modes();
		logic [2:0] exp_pwr [3] = '{3'b001, 3'b011, 3'b111};
		ana.input_valid = 1'b1;
		ana.battery_present = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			host_u.write(8'h09, 8'(k));
			repeat (6) @(posedge ref_clk);
			check({5'h0, power_ctl}, {5'h0, exp_pwr[k]});
			check({7'h0, charging_ok_flag}, {7'h0, k == 2});
		end
	endtask

	task automatic t_end_of_charge();
		host_u.write(8'h0a, 8'h02);
		ana.cv_mode = 1'b1;
		ana.at_termination = 1'b1;
		repeat (8) @(posedge ref_clk);
		rd_check(8'h07, 8'h03);
		repeat (40) @(posedge ref_clk);
		rd_check(8'h07, 8'h03);
		repeat (20) @(posedge ref_clk);
		rd_check(8'h07, 8'h04);
		ana.cv_mode = 1'b0;
		ana.at_termination = 1'b0;
		host_u.write(8'h0d, 8'h43);
		ana.below_restart = 1'b1;
		repeat (6) @(posedge ref_clk);
		rd_check(8'h07, 8'h04);
		host_u.write(8'h0d, 8'h41);
		repeat (6) @(posedge ref_clk);
		rd_check(8'h07, 8'h02);
		ana.below_restart = 1'b0;
		host_u.write(8'h09, 8'h00);
	endtask

	// 30 min of 4-cycle seconds is 7200 cycles from entering precharge
	task automatic t_precharge();
		ana.battery_low = 1'b1;
		host_u.write(8'h0a, 8'h0a);
		host_u.write(8'h09, 8'h02);
		repeat (10) @(posedge ref_clk);
		rd_check(8'h07, 8'h01);
		repeat (7140) @(posedge ref_clk);
		rd_check(8'h07, 8'h01);
		repeat (100) @(posedge ref_clk);
		rd_check(8'h07, 8'h05);
		check({7'h0, power_ctl.charger_enable}, 8'h00);
		host_u.write(8'h09, 8'h00);
		ana.battery_low = 1'b0;
	endtask

	task automatic t_watchdog();
		logic [7:0] d;
		host_u.write(8'h09, 8'h0a);
		for (int k = 0; k < 4; k++)
		begin
			repeat (6) @(posedge ref_clk);
			host_u.wdog_clear();
		end
		check({7'h0, watchdog_expired_flag}, 8'h00);
		check({7'h0, charging_ok_flag}, 8'h01);
		repeat (25) @(posedge ref_clk);
		check({7'h0, watchdog_expired_flag}, 8'h01);
		check({7'h0, power_ctl.charger_enable}, 8'h00);
		check({7'h0, charging_ok_flag}, 8'h00);
		host_u.read(8'h07, d);
		check({7'h0, d[5]}, 8'h01);
		host_u.write(8'h0c, 8'h02);
		repeat (3) @(posedge ref_clk);
		check({7'h0, watchdog_expired_flag}, 8'h01);
		host_u.wdog_clear();
		repeat (2) @(posedge ref_clk);
		check({7'h0, watchdog_expired_flag}, 8'h00);
		host_u.write(8'h09, 8'h00);
	endtask

	task automatic t_fields();
		host_u.write(8'h09, 8'hf4);
		rd_check(8'h09, 8'hf4);
		repeat (3) @(posedge ref_clk);
		check({5'h0, power_ctl}, 8'h00);
		host_u.write(8'h0a, 8'hff);
		rd_check(8'h0a, 8'hbf);
		for (int k = 0; k < 5; k++)
		begin
			host_u.write(8'h0d, 8'h0f | 8'(k << 4));
			rd_check(8'h0d, 8'h0f | 8'(k << 4));
			check({3'h0, charge_cfg}, 8'(k << 2) | 8'h03);
		end
		host_u.write(8'h0d, 8'h02);
		repeat (2) @(posedge ref_clk);
		check({3'h0, charge_cfg}, 8'h02);
	endtask

	task automatic t_midreset();
		@(posedge ref_clk);
		#1;
		rst_b = 1'b0;
		repeat (2) @(posedge ref_clk);
		check({5'h0, power_ctl}, 8'h00);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge ref_clk);
		rd_check(8'h09, 8'h02);
		rd_check(8'h0a, 8'h0a);
		rd_check(8'h0d, 8'h41);
	endtask

	// ----------------------------------------
	// clock, reset and sequence
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial
	begin
		#(40 * 20000);
		fail_count++;
		results();
	end

	initial
	begin
		rst_b = 1'b0;
		otp = 2'b10;
		ana = '0;
		repeat (2) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge ref_clk);
		t_defaults();
		t_modes();
		t_end_of_charge();
		t_precharge();
		t_watchdog();
		t_fields();
		t_midreset();
		results();
	end
endmodule
